/* File: hw/clock_gate_consts.vh */
`ifndef CLOCK_GATE_CONSTS_VH
`define CLOCK_GATE_CONSTS_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define RUN_GATE_GROUP1_OFS        12'h104
`define RUN_GATE_GROUP2_OFS        12'h108
`define SLEEP_GATE_GROUP1_OFS      12'h114
`define SLEEP_GATE_GROUP2_OFS      12'h118
`define DEEP_SLEEP_GATE_GROUP1_OFS 12'h124
`define DEEP_SLEEP_GATE_GROUP2_OFS 12'h128
`define CLOCK_FAULT_CLEAR_OFS      12'h150
`define REGULATOR_RESET_ENABLE_OFS 12'h160
`define RUN_CLOCK_CONFIG_OFS       12'h060
`define IRQ_STATUS_OFS             12'h170
`define IRQ_MASK_OFS               12'h174
`define FAULT_STATUS_OFS           12'h178
// ----------------------------------------
// field positions
// ----------------------------------------
`define COMPARATOR_ONE_GATE_BIT    25
`define COMPARATOR_ZERO_GATE_BIT   24
`define TIMER_ONE_GATE_BIT         17
`define TIMER_ZERO_GATE_BIT        16
`define SYNC_SERIAL_GATE_BIT       4
`define SERIAL_PORT_ZERO_GATE_BIT  0
`define GPIO_C_GATE_BIT            2
`define GPIO_B_GATE_BIT            1
`define GPIO_A_GATE_BIT            0
`define FAULT_CLEAR_BIT            0
`define REGULATOR_RESET_BIT        0
`define INTERNAL_OSC_CHECK_BIT     3
`define MAIN_OSC_CHECK_BIT         2
`define AUTO_GATING_BIT            27
`define IRQ_MAIN_OSC_BIT           0
`define IRQ_INTERNAL_OSC_BIT       1
// ----------------------------------------
// writable masks and reset values
// ----------------------------------------
`define GROUP1_WR_MASK             32'h0303_0011
`define GROUP2_WR_MASK             32'h0000_0007
`define RUN_CLOCK_CONFIG_WR_MASK   32'h0800_000C
`define GATE_RESET_VALUE           32'h0000_0000
`define WORD_ZERO                  32'h0000_0000
// ----------------------------------------
// timing
// ----------------------------------------
`define CLOCK_HZ                   10000000
`define OSC_CHECK_TIMEOUT_US       100
`define OSC_CHECK_TIMEOUT_CYCLES   ((`OSC_CHECK_TIMEOUT_US * (`CLOCK_HZ / 1000000)))
`endif

/* File: hw/osc_check_timer.v */
`timescale 1ns/100ps
// watchdog on one oscillator's activity ticks
module osc_check_timer #(
	parameter TIMEOUT = 1000
) (
	// clock and reset
	input  wire ref_clk_i,
	input  wire rst_i,
	// control
	input  wire enable_i,
	input  wire osc_tick_i,
	// result
	output reg  stopped_o
);
	reg [31:0] count_reg;

	// timer only counts while enabled; a tick restarts it
	always @(posedge ref_clk_i) begin
		if (rst_i || !enable_i || osc_tick_i) begin
			count_reg <= 32'h0000_0000;
			stopped_o <= 1'b0;
		end else if (count_reg >= TIMEOUT - 1) begin
			stopped_o <= 1'b1;
		end else begin
			count_reg <= count_reg + 32'h0000_0001;
			stopped_o <= 1'b0;
		end
	end
endmodule

/* File: hw/peripheral_clock_gating_ctrl.v */
// The plain strobed port was left to the implementer.
`timescale 1ns/100ps
`include "clock_gate_consts.vh"
// Notes on behaviour
// - gate bit one clocks unit, zero stops it
// - all gate enables clear at reset
// - run, sleep, deep-sleep sets by mode
// - sleep sets used only with auto gating
// - group one bits 25,24 gate comparators
// - group one bits 17,16 gate timers
// - bit 4 sync serial, bit 0 serial port
// - group two bits 2..0 gate gpio C,B,A
// - reserved bits read zero, writes ignored
// - fault clear bit never self-clears
// - fault forces known good clock select
// - regulator reset only when enable set
// - osc checkers run when enabled, interrupt
module peripheral_clock_gating_ctrl #(
	parameter OSC_TIMEOUT = `OSC_CHECK_TIMEOUT_CYCLES
) (
	// clock and reset
	input  wire        ref_clk_i,
	input  wire        rst_i,
	// register port
	input  wire [11:0] addr_i,
	input  wire [31:0] wdata_i,
	input  wire        wr_i,
	input  wire        rd_i,
	output reg  [31:0] rdata_o,
	// power mode and monitors
	input  wire        sleep_i,
	input  wire        deep_sleep_i,
	input  wire        main_osc_tick_i,
	input  wire        internal_osc_tick_i,
	input  wire        regulator_unregulated_i,
	// unit clock enables
	output reg         comparator_one_gate_o,
	output reg         comparator_zero_gate_o,
	output reg         timer_one_gate_o,
	output reg         timer_zero_gate_o,
	output reg         sync_serial_gate_o,
	output reg         serial_port_zero_gate_o,
	output reg         gpio_a_gate_o,
	output reg         gpio_b_gate_o,
	output reg         gpio_c_gate_o,
	// system
	output reg         safe_clock_select_o,
	output reg         regulator_reset_o,
	output reg         irq_o
);
	// ----------------------------------------
	// registers
	// ----------------------------------------
	reg [31:0] run_gate_group1_reg;
	reg [31:0] run_gate_group2_reg;
	reg [31:0] sleep_gate_group1_reg;
	reg [31:0] sleep_gate_group2_reg;
	reg [31:0] deep_sleep_gate_group1_reg;
	reg [31:0] deep_sleep_gate_group2_reg;
	reg [31:0] run_clock_config_reg;
	reg        fault_clear_bit_reg;
	reg        regulator_reset_enable_reg;
	reg [1:0]  irq_status_reg;
	reg [1:0]  irq_mask_reg;
	reg        fault_reg;
	reg [31:0] rdata_next;
	reg [31:0] gate1_next;
	reg [31:0] gate2_next;
	wire       main_stopped;
	wire       internal_stopped;
	wire [1:0] irq_event;
	wire [1:0] irq_clear;
	wire       auto_gating_select;

	assign auto_gating_select = run_clock_config_reg[`AUTO_GATING_BIT];
	assign irq_event = {internal_stopped, main_stopped};
	assign irq_clear = (wr_i && addr_i == `IRQ_STATUS_OFS) ? wdata_i[1:0] : 2'h0;

	// ----------------------------------------
	// register writes
	// ----------------------------------------
	// one decoded strobe per register keeps each store independent
	wire run1_wr        = wr_i && (addr_i == `RUN_GATE_GROUP1_OFS);
	wire run2_wr        = wr_i && (addr_i == `RUN_GATE_GROUP2_OFS);
	wire sleep1_wr      = wr_i && (addr_i == `SLEEP_GATE_GROUP1_OFS);
	wire sleep2_wr      = wr_i && (addr_i == `SLEEP_GATE_GROUP2_OFS);
	wire deep1_wr       = wr_i && (addr_i == `DEEP_SLEEP_GATE_GROUP1_OFS);
	wire deep2_wr       = wr_i && (addr_i == `DEEP_SLEEP_GATE_GROUP2_OFS);
	wire config_wr      = wr_i && (addr_i == `RUN_CLOCK_CONFIG_OFS);
	wire fault_clear_wr = wr_i && (addr_i == `CLOCK_FAULT_CLEAR_OFS);
	wire regulator_wr   = wr_i && (addr_i == `REGULATOR_RESET_ENABLE_OFS);
	wire mask_wr        = wr_i && (addr_i == `IRQ_MASK_OFS);

	// ----------------------------------------
	// register storage
	// ----------------------------------------
	// reserved bits masked off on write so they always read zero
	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			run_gate_group1_reg <= `GATE_RESET_VALUE;
		end else if (run1_wr) begin
			run_gate_group1_reg <= wdata_i & `GROUP1_WR_MASK;
		end
	end

	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			run_gate_group2_reg <= `GATE_RESET_VALUE;
		end else if (run2_wr) begin
			run_gate_group2_reg <= wdata_i & `GROUP2_WR_MASK;
		end
	end

	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			sleep_gate_group1_reg <= `GATE_RESET_VALUE;
		end else if (sleep1_wr) begin
			sleep_gate_group1_reg <= wdata_i & `GROUP1_WR_MASK;
		end
	end

	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			sleep_gate_group2_reg <= `GATE_RESET_VALUE;
		end else if (sleep2_wr) begin
			sleep_gate_group2_reg <= wdata_i & `GROUP2_WR_MASK;
		end
	end

	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			deep_sleep_gate_group1_reg <= `GATE_RESET_VALUE;
		end else if (deep1_wr) begin
			deep_sleep_gate_group1_reg <= wdata_i & `GROUP1_WR_MASK;
		end
	end

	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			deep_sleep_gate_group2_reg <= `GATE_RESET_VALUE;
		end else if (deep2_wr) begin
			deep_sleep_gate_group2_reg <= wdata_i & `GROUP2_WR_MASK;
		end
	end

	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			run_clock_config_reg <= `WORD_ZERO;
		end else if (config_wr) begin
			run_clock_config_reg <= wdata_i & `RUN_CLOCK_CONFIG_WR_MASK;
		end
	end

	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			fault_clear_bit_reg <= 1'b0;
		end else if (fault_clear_wr) begin
			fault_clear_bit_reg <= wdata_i[`FAULT_CLEAR_BIT];
		end
	end

	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			regulator_reset_enable_reg <= 1'b0;
		end else if (regulator_wr) begin
			regulator_reset_enable_reg <= wdata_i[`REGULATOR_RESET_BIT];
		end
	end

	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			irq_mask_reg <= 2'h0;
		end else if (mask_wr) begin
			irq_mask_reg <= wdata_i[1:0];
		end
	end

	// ----------------------------------------
	// oscillator checks
	// ----------------------------------------
	osc_check_timer #(
		.TIMEOUT (OSC_TIMEOUT)
	) main_check (
		.ref_clk_i  (ref_clk_i),
		.rst_i      (rst_i),
		.enable_i   (run_clock_config_reg[`MAIN_OSC_CHECK_BIT]),
		.osc_tick_i (main_osc_tick_i),
		.stopped_o  (main_stopped)
	);

	osc_check_timer #(
		.TIMEOUT (OSC_TIMEOUT)
	) internal_check (
		.ref_clk_i  (ref_clk_i),
		.rst_i      (rst_i),
		.enable_i   (run_clock_config_reg[`INTERNAL_OSC_CHECK_BIT]),
		.osc_tick_i (internal_osc_tick_i),
		.stopped_o  (internal_stopped)
	);

	// ----------------------------------------
	// fault latch
	// ----------------------------------------
	// a new stop wins over a clear in the same cycle
	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			fault_reg <= 1'b0;
		end else if (|irq_event) begin
			fault_reg <= 1'b1;
		end else if (fault_clear_bit_reg) begin
			fault_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// interrupt status and line
	// ----------------------------------------
	// irq follows the status it is about to hold, so no extra cycle of lag
	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			irq_status_reg <= 2'h0;
			irq_o          <= 1'b0;
		end else begin
			irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_event;
			irq_o          <= |(((irq_status_reg & ~irq_clear) | irq_event) & irq_mask_reg);
		end
	end

	// ----------------------------------------
	// power mode decode
	// ----------------------------------------
	localparam MODE_RUN   = 2'h0;
	localparam MODE_SLEEP = 2'h1;
	localparam MODE_DEEP  = 2'h2;

	reg [1:0] power_mode;

	// deep sleep wins when both mode inputs are high
	always @* begin
		power_mode = MODE_RUN;
		if (auto_gating_select) begin
			if (deep_sleep_i) begin
				power_mode = MODE_DEEP;
			end else if (sleep_i) begin
				power_mode = MODE_SLEEP;
			end
		end
	end

	// ----------------------------------------
	// gate selection
	// ----------------------------------------
	always @* begin
		case (power_mode)
		MODE_SLEEP: begin
			gate1_next = sleep_gate_group1_reg;
			gate2_next = sleep_gate_group2_reg;
		end
		MODE_DEEP: begin
			gate1_next = deep_sleep_gate_group1_reg;
			gate2_next = deep_sleep_gate_group2_reg;
		end
		default: begin
			gate1_next = run_gate_group1_reg;
			gate2_next = run_gate_group2_reg;
		end
		endcase
	end

	// ----------------------------------------
	// unit clock enables
	// ----------------------------------------
	// enables are registered, so the downstream latch-based gate stays glitch free
	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			comparator_one_gate_o   <= 1'b0;
			comparator_zero_gate_o  <= 1'b0;
			timer_one_gate_o        <= 1'b0;
			timer_zero_gate_o       <= 1'b0;
			sync_serial_gate_o      <= 1'b0;
			serial_port_zero_gate_o <= 1'b0;
		end else begin
			comparator_one_gate_o   <= gate1_next[`COMPARATOR_ONE_GATE_BIT];
			comparator_zero_gate_o  <= gate1_next[`COMPARATOR_ZERO_GATE_BIT];
			timer_one_gate_o        <= gate1_next[`TIMER_ONE_GATE_BIT];
			timer_zero_gate_o       <= gate1_next[`TIMER_ZERO_GATE_BIT];
			sync_serial_gate_o      <= gate1_next[`SYNC_SERIAL_GATE_BIT];
			serial_port_zero_gate_o <= gate1_next[`SERIAL_PORT_ZERO_GATE_BIT];
		end
	end

	// ports switch on the same edge as the group one units
	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			gpio_a_gate_o <= 1'b0;
			gpio_b_gate_o <= 1'b0;
			gpio_c_gate_o <= 1'b0;
		end else begin
			gpio_a_gate_o <= gate2_next[`GPIO_A_GATE_BIT];
			gpio_b_gate_o <= gate2_next[`GPIO_B_GATE_BIT];
			gpio_c_gate_o <= gate2_next[`GPIO_C_GATE_BIT];
		end
	end

	// ----------------------------------------
	// system outputs
	// ----------------------------------------
	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			safe_clock_select_o <= 1'b0;
			regulator_reset_o   <= 1'b0;
		end else begin
			safe_clock_select_o <= fault_reg;
			regulator_reset_o   <= regulator_reset_enable_reg
				&& regulator_unregulated_i;
		end
	end

	// ----------------------------------------
	// read back
	// ----------------------------------------
	always @* begin
		rdata_next = `WORD_ZERO;
		case (addr_i)
		`RUN_GATE_GROUP1_OFS:        rdata_next = run_gate_group1_reg;
		`RUN_GATE_GROUP2_OFS:        rdata_next = run_gate_group2_reg;
		`SLEEP_GATE_GROUP1_OFS:      rdata_next = sleep_gate_group1_reg;
		`SLEEP_GATE_GROUP2_OFS:      rdata_next = sleep_gate_group2_reg;
		`DEEP_SLEEP_GATE_GROUP1_OFS: rdata_next = deep_sleep_gate_group1_reg;
		`DEEP_SLEEP_GATE_GROUP2_OFS: rdata_next = deep_sleep_gate_group2_reg;
		`RUN_CLOCK_CONFIG_OFS:       rdata_next = run_clock_config_reg;
		`CLOCK_FAULT_CLEAR_OFS:      rdata_next = {31'h0000_0000, fault_clear_bit_reg};
		`REGULATOR_RESET_ENABLE_OFS: rdata_next = {31'h0000_0000, regulator_reset_enable_reg};
		`IRQ_STATUS_OFS:             rdata_next = {30'h0000_0000, irq_status_reg};
		`IRQ_MASK_OFS:               rdata_next = {30'h0000_0000, irq_mask_reg};
		`FAULT_STATUS_OFS:           rdata_next = {31'h0000_0000, fault_reg};
		default:                     rdata_next = `WORD_ZERO;
		endcase
	end

	// unmapped reads return zero; data held only in the cycle after the strobe
	always @(posedge ref_clk_i) begin
		if (rst_i || !rd_i) begin
			rdata_o <= `WORD_ZERO;
		end else begin
			rdata_o <= rdata_next;
		end
	end
endmodule

/* File: verification/peripheral_clock_gating_ctrl_asserts.sv */
`timescale 1ns/100ps
// ----------------------------------------
// port checks
// ----------------------------------------
module gating_ctrl_asserts #(
	parameter OSC_TIMEOUT = 8
) (
	input wire        ref_clk_i, rst_i, wr_i, rd_i, sleep_i, deep_sleep_i,
	input wire [11:0] addr_i,
	input wire [31:0] wdata_i, rdata_o,
	input wire        main_osc_tick_i, internal_osc_tick_i, regulator_unregulated_i,
	input wire        comparator_one_gate_o, comparator_zero_gate_o, timer_one_gate_o,
	input wire        timer_zero_gate_o, sync_serial_gate_o, serial_port_zero_gate_o,
	input wire        gpio_a_gate_o, gpio_b_gate_o, gpio_c_gate_o,
	input wire        safe_clock_select_o, regulator_reset_o, irq_o
);
	wire [8:0] gates = {comparator_one_gate_o, comparator_zero_gate_o, timer_one_gate_o,
		timer_zero_gate_o, sync_serial_gate_o, serial_port_zero_gate_o,
		gpio_c_gate_o, gpio_b_gate_o, gpio_a_gate_o};
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	property p_reset_clear;
		$fell(rst_i) |-> gates == 9'h000 && !safe_clock_select_o && !irq_o && !regulator_reset_o;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("output set after reset");
	property p_grp1_rsvd;
		$past(rd_i) && $past(addr_i) inside {12'h104, 12'h114, 12'h124}
			|-> (rdata_o & 32'hFCFC_FFEE) == 32'h0000_0000;
	endproperty
	a_grp1_rsvd: assert property (p_grp1_rsvd) else $error("group1 spare bit read");
	property p_grp2_rsvd;
		$past(rd_i) && $past(addr_i) inside {12'h108, 12'h118, 12'h128} |-> rdata_o[31:3] == 0;
	endproperty
	a_grp2_rsvd: assert property (p_grp2_rsvd) else $error("group2 spare bit read");
	property p_gate_cause;
		$changed(gates) |-> $past(wr_i, 2) || $past(sleep_i) != $past(sleep_i, 2) ||
			$past(deep_sleep_i) != $past(deep_sleep_i, 2);
	endproperty
	a_gate_cause: assert property (p_gate_cause) else $error("gate moved uncaused");
	property p_regulator_reset; regulator_reset_o |-> $past(regulator_unregulated_i); endproperty
	a_regulator_reset: assert property (p_regulator_reset) else $error("bad reset");
	property p_safe_cause;
		$rose(safe_clock_select_o) |-> $past(main_osc_tick_i, 2) == 0 ||
			$past(internal_osc_tick_i, 2) == 0;
	endproperty
	a_safe_cause: assert property (p_safe_cause) else $error("safe clock with osc alive");
	property p_irq_rise; $rose(irq_o) && !$past(wr_i, 2) |-> ##[0:1] safe_clock_select_o; endproperty
	a_irq_rise: assert property (p_irq_rise) else $error("irq with no cause");
	property p_irq_fall; $fell(irq_o) |-> $past(wr_i) || $past(wr_i, 2); endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("irq dropped alone");
endmodule

bind peripheral_clock_gating_ctrl gating_ctrl_asserts #(.OSC_TIMEOUT(OSC_TIMEOUT)) u_chk (
	.ref_clk_i, .rst_i, .wr_i, .rd_i, .sleep_i, .deep_sleep_i, .addr_i, .wdata_i, .rdata_o,
	.main_osc_tick_i, .internal_osc_tick_i, .regulator_unregulated_i, .comparator_one_gate_o,
	.comparator_zero_gate_o, .timer_one_gate_o, .timer_zero_gate_o, .sync_serial_gate_o,
	.serial_port_zero_gate_o, .gpio_a_gate_o, .gpio_b_gate_o, .gpio_c_gate_o,
	.safe_clock_select_o, .regulator_reset_o, .irq_o);

/* File: verification/gated_unit_model.sv */
`timescale 1ns/100ps
// ----------------------------------------
// gated units: only run while clocked
// ----------------------------------------
module gated_unit_model (
	input  wire       ref_clk_i,
	input  wire       clear_i,
	input  wire [8:0] gate_i,
	output reg  [8:0] ran_o
);
	// no clock of their own, so activity only while gated on
	always @(posedge ref_clk_i) begin
		if (clear_i) begin
			ran_o <= 9'h000;
		end else begin
			ran_o <= ran_o | gate_i;
		end
	end
endmodule

/* File: verification/tb_peripheral_clock_gating_ctrl.sv */
`timescale 1ns/100ps
module tb_peripheral_clock_gating_ctrl;
	logic        ref_clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
	logic        sleep_i = 1'b0, deep_sleep_i = 1'b0, main_tick = 1'b0, int_tick = 1'b0;
	logic        osc_run = 1'b1, int_run = 1'b1, unreg = 1'b0, clr = 1'b1;
	logic [11:0] addr_i = 12'h000;
	logic [31:0] wdata_i = 32'h0000_0000, d;
	wire  [31:0] rdata_o;
	wire  [8:0]  gates, ran;
	wire         safe, irq, regulator_rst;
	int          errors = 0, comparisons = 0;
	always #50 ref_clk_i = ~ref_clk_i;
	// osc_run or int_run low fakes a dead oscillator
	always @(posedge ref_clk_i) begin
		main_tick <= osc_run & ~main_tick;
		int_tick  <= int_run & ~int_tick;
	end
	peripheral_clock_gating_ctrl #(.OSC_TIMEOUT(8)) DUT (
		.ref_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .sleep_i, .deep_sleep_i,
		.main_osc_tick_i(main_tick), .internal_osc_tick_i(int_tick),
		.regulator_unregulated_i(unreg), .comparator_one_gate_o(gates[8]),
		.comparator_zero_gate_o(gates[7]), .timer_one_gate_o(gates[6]),
		.timer_zero_gate_o(gates[5]), .sync_serial_gate_o(gates[4]),
		.serial_port_zero_gate_o(gates[3]), .gpio_c_gate_o(gates[2]), .gpio_b_gate_o(gates[1]),
		.gpio_a_gate_o(gates[0]), .safe_clock_select_o(safe), .irq_o(irq),
		.regulator_reset_o(regulator_rst));
	gated_unit_model partner (.ref_clk_i, .clear_i(clr), .gate_i(gates), .ran_o(ran));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		@(posedge ref_clk_i);
		addr_i  <= a;
		wdata_i <= v;
		wr_i    <= 1'b1;
		@(posedge ref_clk_i);
		wr_i    <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a);
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge ref_clk_i);
		rd_i   <= 1'b0;
		@(negedge ref_clk_i);
		d = rdata_o;
	endtask
	task automatic wrap_up();
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		logic [11:0] ofs[10] = '{12'h104, 12'h108, 12'h114, 12'h118, 12'h124, 12'h128,
			12'h150, 12'h160, 12'h060, 12'h0F0};
		chk(32'(gates), 32'h0000_0000);
		foreach (ofs[i]) begin
			rd(ofs[i]);
			chk(d, 32'h0000_0000);
		end
	endtask
	task automatic t_map();
		int pos[9] = '{25, 24, 17, 16, 4, 0, 2, 1, 0};
		logic [11:0] a;
		for (int i = 0; i < 9; i++) begin
			a = (i < 6) ? 12'h104 : 12'h108;
			@(posedge ref_clk_i);
			clr <= 1'b1;
			@(posedge ref_clk_i);
			clr <= 1'b0;
			wr(a, 32'h0000_0001 << pos[i]);
			repeat (3) @(negedge ref_clk_i);
			chk(32'(gates), 32'(9'h100 >> i));
			chk(32'(ran), 32'(9'h100 >> i));
			rd(a);
			chk(d, 32'h0000_0001 << pos[i]);
			wr(a, 32'h0000_0000);
		end
		wr(12'h104, 32'hFFFF_FFFF);
		wr(12'h118, 32'hFFFF_FFFF);
		rd(12'h104);
		chk(d, 32'h0303_0011);
		rd(12'h118);
		chk(d, 32'h0000_0007);
		wr(12'h104, 32'h0000_0000);
	endtask
	task automatic t_modes();
		wr(12'h108, 32'h0000_0001);
		wr(12'h118, 32'h0000_0002);
		wr(12'h128, 32'h0000_0004);
		sleep_i <= 1'b1;
		repeat (3) @(negedge ref_clk_i);
		chk(32'(gates), 32'h0000_0001);
		wr(12'h060, 32'h0800_0000);
		repeat (3) @(negedge ref_clk_i);
		chk(32'(gates), 32'h0000_0002);
		@(posedge ref_clk_i);
		deep_sleep_i <= 1'b1;
		repeat (3) @(negedge ref_clk_i);
		chk(32'(gates), 32'h0000_0004);
		@(posedge ref_clk_i);
		sleep_i      <= 1'b0;
		deep_sleep_i <= 1'b0;
		repeat (3) @(negedge ref_clk_i);
		chk(32'(gates), 32'h0000_0001);
		wr(12'h060, 32'h0000_0000);
		wr(12'h108, 32'h0000_0000);
	endtask
	task automatic t_fault();
		osc_run <= 1'b0;
		repeat (20) @(negedge ref_clk_i);
		chk(32'(safe), 32'h0000_0000);
		wr(12'h060, 32'h0000_0004);
		for (int i = 0; i < 40 && safe !== 1'b1; i++) @(negedge ref_clk_i);
		chk(32'(safe), 32'h0000_0001);
		chk(32'(irq), 32'h0000_0000);
		wr(12'h174, 32'h0000_0001);
		repeat (2) @(negedge ref_clk_i);
		chk(32'(irq), 32'h0000_0001);
		rd(12'h170);
		chk(d, 32'h0000_0001);
		@(posedge ref_clk_i);
		osc_run <= 1'b1;
		repeat (4) @(negedge ref_clk_i);
		chk(32'(safe), 32'h0000_0001);
		wr(12'h150, 32'h0000_0001);
		repeat (3) @(negedge ref_clk_i);
		chk(32'(safe), 32'h0000_0000);
		rd(12'h150);
		chk(d, 32'h0000_0001);
		wr(12'h150, 32'h0000_0000);
		wr(12'h170, 32'h0000_0001);
		repeat (2) @(negedge ref_clk_i);
		chk(32'(irq), 32'h0000_0000);
		wr(12'h060, 32'h0000_0000);
	endtask
	task automatic t_internal();
		@(posedge ref_clk_i);
		int_run <= 1'b0;
		wr(12'h060, 32'h0000_0008);
		repeat (20) @(negedge ref_clk_i);
		chk(32'(safe), 32'h0000_0001);
		chk(32'(irq), 32'h0000_0000);
		rd(12'h170);
		chk(d, 32'h0000_0002);
		rd(12'h178);
		chk(d, 32'h0000_0001);
		@(posedge ref_clk_i);
		int_run <= 1'b1;
		repeat (3) @(posedge ref_clk_i);
		wr(12'h150, 32'h0000_0001);
		wr(12'h150, 32'h0000_0000);
		repeat (3) @(negedge ref_clk_i);
		chk(32'(safe), 32'h0000_0000);
		wr(12'h170, 32'h0000_0002);
		rd(12'h170);
		chk(d, 32'h0000_0000);
		wr(12'h060, 32'h0000_0000);
	endtask
	task automatic t_regulator();
		@(posedge ref_clk_i);
		unreg <= 1'b1;
		repeat (3) @(negedge ref_clk_i);
		chk(32'(regulator_rst), 32'h0000_0000);
		wr(12'h160, 32'h0000_0001);
		repeat (2) @(negedge ref_clk_i);
		chk(32'(regulator_rst), 32'h0000_0001);
		@(posedge ref_clk_i);
		unreg <= 1'b0;
		repeat (2) @(negedge ref_clk_i);
		chk(32'(regulator_rst), 32'h0000_0000);
	endtask
	initial begin
		repeat (10) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		clr   <= 1'b0;
		t_reset();
		t_map();
		t_modes();
		t_fault();
		t_internal();
		t_regulator();
		wrap_up();
	end
	initial begin
		repeat (20000) @(posedge ref_clk_i);
		errors++;
		wrap_up();
	end
endmodule
